// ==== epd_pkg.sv ====
// Constants shared by the end-of-interrupt and priority-drop block.
// Assumes a 32-bit APB register bus and 8-bit priority values.
package epd_pkg;

	// Register byte offsets.
	localparam logic [11:0] EPD_OFF_CTRL   = 12'h000;
	localparam logic [11:0] EPD_OFF_RPR    = 12'h004;
	localparam logic [11:0] EPD_OFF_APR_S  = 12'h008;
	localparam logic [11:0] EPD_OFF_APR_NS = 12'h00C;
	localparam logic [11:0] EPD_OFF_EOI    = 12'h010;
	localparam logic [11:0] EPD_OFF_AEOI   = 12'h014;

	// Control register fields.
	localparam int EPD_CTRL_ACK  = 0;
	localparam int EPD_CTRL_SEOI = 1;
	localparam int EPD_CTRL_NEOI = 2;
	localparam logic [2:0] EPD_CTRL_RST = 3'h0;

	// End-of-interrupt word fields.
	localparam int EPD_ID_LSB  = 0;
	localparam int EPD_ID_W    = 10;
	localparam int EPD_SRC_LSB = 10;
	localparam int EPD_SRC_W   = 3;

	// Priority values.
	localparam int          EPD_PRIO_W    = 8;
	localparam logic [7:0]  EPD_IDLE_PRIO = 8'hFF;
	localparam logic [7:0]  EPD_NS_THRESH = 8'h80;
	localparam logic [7:0]  EPD_NS_ZERO   = 8'h00;
	localparam logic [9:0]  EPD_SPUR_MIN  = 10'h3FC;
	localparam int          EPD_PPROT_NS  = 1;

	typedef enum logic [1:0] {
		EPD_DROP_NONE = 2'b00,
		EPD_DROP_G0   = 2'b01,
		EPD_DROP_G1   = 2'b10,
		EPD_DROP_ANY  = 2'b11
	} epd_drop_e;

endpackage

// ==== epd_find_if.sv ====
// Carrier between the block and its highest-active-level finder.
// Assumes both ends share pclk; it holds no state.
`timescale 1ns/10ps
interface epd_find_if #(
	parameter int N = 32,
	parameter int W = 5
);
	logic [N-1:0] active;
	logic         found;
	logic [W-1:0] index;

	modport finder (input active, output found, output index);
	modport user   (output active, input found, input index);
endinterface

// ==== epd_find_first.sv ====
// Finds the lowest set bit of an active-priority vector.
// Assumes index 0 is the highest priority level.
`timescale 1ns/10ps
module epd_find_first #(
	parameter int N = 32,
	parameter int W = 5
) (
	epd_find_if.finder f
);
	always_comb begin
		f.found = 1'b0;
		f.index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (f.active[i]) begin
				f.found = 1'b1;
				f.index = W'(i);
			end
		end
	end
endmodule

// ==== epd_eoi_ctrl.sv ====
// End-of-interrupt, priority-drop and running-priority logic of one
// processor interface, reached over APB.
// Assumes activations arrive from acknowledge logic on pclk, and the
// group of an identified interrupt is answered combinationally.
//
// Overview of operation
// - With shared ack off, Secure EOI completes Group 0, alias EOI Group 1.
// - Secure split mode governs Secure EOI and alias EOI writes, non-secure mode Non-secure EOI writes.
// - Non-secure EOI with Group 1 highest active drops highest Group 1 level.
// - Non-secure EOI never changes active Group 0 priority levels.
// - Secure EOI with shared ack off drops highest Group 0 level.
// - Secure EOI with shared ack on drops the single highest level.
// - Without security support every access behaves as Secure.
// - Split mode off deactivates per group, security and shared ack.
// - Split mode on only drops priority; the interrupt stays active.
// - Running priority sits in bits 7:0, upper bits read zero.
// - With nothing active running priority and Secure reads give the idle value.
// - Non-secure read gives zero below 0x80, else the shifted view.
// - Unimplemented low priority bits read as zero unless nothing is active.
// - EOI writes naming a spurious identifier are ignored.
`timescale 1ns/10ps
module epd_eoi_ctrl
	import epd_pkg::*;
#(
	parameter bit SECURITY  = 1'b1,
	parameter int PRIO_BITS = 5
) (
	// Clock, reset and enable.
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [2:0]           pprot,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Activation from the acknowledge logic.
	input  wire logic                 act_valid,
	input  wire logic [7:0]           act_prio,
	input  wire logic                 act_group1,
	// Group lookup for the identified interrupt.
	output logic      [EPD_ID_W-1:0]  query_id,
	input  wire logic                 query_group1,
	// Deactivation towards the distributor.
	output logic                      deact_valid,
	output logic      [EPD_ID_W-1:0]  deact_id,
	output logic      [EPD_SRC_W-1:0] deact_src,
	// Running priority for the rest of the interface.
	output logic      [7:0]           running_prio
);

	localparam int LEVELS = 1 << PRIO_BITS;
	localparam int LSH    = EPD_PRIO_W - PRIO_BITS;

	// Priority level back to an 8-bit value, unimplemented bits zero.
	function automatic logic [7:0] lvl_to_prio(
		input logic [PRIO_BITS-1:0] lvl
	);
		logic [7:0] p;
		p = 8'({lvl, {LSH{1'b0}}});
		return p;
	endfunction

	function automatic logic [LEVELS-1:0] onehot(
		input logic [PRIO_BITS-1:0] lvl
	);
		logic [LEVELS-1:0] v;
		v = '0;
		v[lvl] = 1'b1;
		return v;
	endfunction

	logic [2:0]        ctrl_q, ctrl_d;
	logic [LEVELS-1:0] apr_s_q, apr_s_d;
	logic [LEVELS-1:0] apr_ns_q, apr_ns_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              deact_q;
	logic [EPD_ID_W-1:0]  deact_id_q;
	logic [EPD_SRC_W-1:0] deact_src_q;

	// Finders for the highest active level of each group.
	epd_find_if #(.N(LEVELS), .W(PRIO_BITS)) f0 ();
	epd_find_if #(.N(LEVELS), .W(PRIO_BITS)) f1 ();
	assign f0.active = apr_s_q;
	assign f1.active = apr_ns_q;
	epd_find_first #(.N(LEVELS), .W(PRIO_BITS)) u_find0 (.f(f0));
	epd_find_first #(.N(LEVELS), .W(PRIO_BITS)) u_find1 (.f(f1));

	// Access decode.
	wire logic ns_acc   = SECURITY && pprot[EPD_PPROT_NS];
	wire logic setup    = psel && !penable;
	wire logic wr_take  = ce && psel && penable && pwrite;
	wire logic hit_ctrl = paddr == EPD_OFF_CTRL;
	wire logic hit_rpr  = paddr == EPD_OFF_RPR;
	wire logic hit_aprs = paddr == EPD_OFF_APR_S;
	wire logic hit_aprn = paddr == EPD_OFF_APR_NS;
	wire logic hit_eoi  = paddr == EPD_OFF_EOI;
	wire logic hit_aeoi = paddr == EPD_OFF_AEOI;
	wire logic mapped   = hit_ctrl || hit_rpr || hit_aprs || hit_aprn ||
	                      hit_eoi || hit_aeoi;

	wire logic shared   = ctrl_q[EPD_CTRL_ACK];
	// Non-secure accesses see only their own split-mode bit.
	wire logic split    = ns_acc ? ctrl_q[EPD_CTRL_NEOI]
	                             : ctrl_q[EPD_CTRL_SEOI];

	// The EOI word: identifier and source core field.
	wire logic [EPD_ID_W-1:0]  wr_id  = pwdata[EPD_ID_LSB +: EPD_ID_W];
	wire logic [EPD_SRC_W-1:0] wr_src = pwdata[EPD_SRC_LSB +: EPD_SRC_W];
	wire logic spurious = wr_id >= EPD_SPUR_MIN;
	// An alias EOI is Secure-only; a Non-secure one is dropped.
	wire logic alias_ok = hit_aeoi && !ns_acc;
	wire logic eoi_take = wr_take && !spurious && (hit_eoi || alias_ok);
	assign query_id = wr_id;

	// Highest active level overall; a tie goes to Group 0.
	wire logic g1_top = f1.found && (!f0.found || f1.index < f0.index);

	// Which group loses its highest level.
	epd_drop_e drop;
	always_comb begin
		drop = EPD_DROP_NONE;
		if (ns_acc) begin
			if (g1_top) begin
				drop = EPD_DROP_G1;
			end
			// Otherwise Group 0 levels stay untouched.
		end else if (hit_aeoi) begin
			drop = EPD_DROP_G1;
		end else if (!shared) begin
			drop = EPD_DROP_G0;
		end else begin
			drop = EPD_DROP_ANY;
		end
	end

	wire logic clr_g0 = eoi_take && f0.found &&
	                    (drop == EPD_DROP_G0 ||
	                     (drop == EPD_DROP_ANY && !g1_top));
	wire logic clr_g1 = eoi_take && f1.found &&
	                    (drop == EPD_DROP_G1 ||
	                     (drop == EPD_DROP_ANY && g1_top));

	// Deactivation; the unpredictable Secure Group 1 case is ignored.
	wire logic deact_ok =
		ns_acc ? query_group1 :
		hit_aeoi ? query_group1 :
		(!query_group1 || shared);
	wire logic deact_now = eoi_take && !split && deact_ok;

	// New activations win over a drop of the same level in one cycle.
	wire logic [LEVELS-1:0] set_vec =
		onehot(act_prio[EPD_PRIO_W-1 -: PRIO_BITS]);
	always_comb begin
		apr_s_d  = apr_s_q;
		apr_ns_d = apr_ns_q;
		if (clr_g0) begin
			apr_s_d = apr_s_d & ~onehot(f0.index);
		end
		if (clr_g1) begin
			apr_ns_d = apr_ns_d & ~onehot(f1.index);
		end
		if (act_valid && !act_group1) begin
			apr_s_d = apr_s_d | set_vec;
		end
		if (act_valid && act_group1) begin
			apr_ns_d = apr_ns_d | set_vec;
		end
	end

	// Running priority from the current bookkeeping.
	wire logic [PRIO_BITS-1:0] top_lvl = g1_top ? f1.index : f0.index;
	wire logic                 any_act = f0.found || f1.found;
	wire logic [7:0] rpr_val = any_act ? lvl_to_prio(top_lvl)
	                                   : EPD_IDLE_PRIO;
	wire logic [7:0] rpr_ns  = (rpr_val < EPD_NS_THRESH) ? EPD_NS_ZERO
	                         : 8'(rpr_val << 1);
	assign running_prio = rpr_val;

	// Control writes; Non-secure writes reach only their own bit.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_take && hit_ctrl) begin
			if (ns_acc) begin
				ctrl_d[EPD_CTRL_NEOI] = pwdata[EPD_CTRL_NEOI];
			end else begin
				ctrl_d = pwdata[2:0];
			end
		end
	end

	// Read data is captured in setup so the answer comes from a flop.
	always_comb begin
		rdata_d = '0;
		if (hit_ctrl) begin
			rdata_d[2:0] = ns_acc ? (ctrl_q & 3'(1 << EPD_CTRL_NEOI))
			                      : ctrl_q;
		end else if (hit_rpr) begin
			rdata_d[7:0] = ns_acc ? rpr_ns : rpr_val;
		end else if (hit_aprs && !ns_acc) begin
			rdata_d[LEVELS-1:0] = apr_s_q;
		end else if (hit_aprn) begin
			rdata_d[LEVELS-1:0] = apr_ns_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= EPD_CTRL_RST;
			apr_s_q     <= '0;
			apr_ns_q    <= '0;
			rdata_q     <= '0;
			deact_q     <= 1'b0;
			deact_id_q  <= '0;
			deact_src_q <= '0;
		end else if (ce) begin
			ctrl_q      <= ctrl_d;
			apr_s_q     <= apr_s_d;
			apr_ns_q    <= apr_ns_d;
			deact_q     <= deact_now;
			if (setup && !pwrite) begin
				rdata_q <= rdata_d;
			end
			if (deact_now) begin
				deact_id_q  <= wr_id;
				deact_src_q <= wr_src;
			end
		end
	end

	// Zero wait states; a frozen block holds the master off.
	assign pready      = ce;
	assign pslverr     = psel && penable && !mapped;
	assign prdata      = rdata_q;
	assign deact_valid = deact_q;
	assign deact_id    = deact_id_q;
	assign deact_src   = deact_src_q;

endmodule

// ==== epd_chk_assertions.sv ====
// Checker for the end-of-interrupt block, on its top-level ports.
// Assumes one pclk domain; pprot[1] high marks a Non-secure access.
`timescale 1ns/10ps
module epd_chk
	import epd_pkg::*;
(
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// APB.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0]  pprot,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// Interrupt side.
	input wire logic        act_valid,
	input wire logic        query_group1,
	input wire logic        deact_valid,
	input wire logic [9:0]  deact_id,
	input wire logic [2:0]  deact_src,
	input wire logic [7:0]  running_prio
);
	// A shadow of the control bits, since the checker sees only ports.
	logic [2:0] ctl_q;
	wire ns = pprot[1];
	wire acc = psel & penable & pready & pwrite;
	wire rd_rpr = psel & ~penable & ~pwrite & (paddr == EPD_OFF_RPR);
	wire eoi = acc & (paddr == EPD_OFF_EOI | paddr == EPD_OFF_AEOI & ~ns);
	wire spur = pwdata[9:0] >= EPD_SPUR_MIN;
	wire split = ns ? ctl_q[2] : ctl_q[1];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= EPD_CTRL_RST;
		end else if (acc && paddr == EPD_OFF_CTRL) begin
			ctl_q <= ns ? {pwdata[2], ctl_q[1:0]} : pwdata[2:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	idle_reset_a: assert property ($rose(presetn) |->
		running_prio == EPD_IDLE_PRIO) else $error("rp not idle");
	rpr_read_a: assert property (rd_rpr && !ns |=>
		prdata == {24'h0, $past(running_prio)}) else $error("bad rpr");
	ns_view_a: assert property (rd_rpr && ns && running_prio >= 8'h80 |=>
		prdata[7:0] == 8'($past(running_prio) << 1)) else $error("ns view");
	split_keep_a: assert property (eoi && split |=>
		!deact_valid) else $error("split mode deactivated");
	ns_group0_a: assert property (eoi && ns && !query_group1 |=>
		!deact_valid) else $error("ns group 0 deactivated");
	s_group0_a: assert property (eoi && !ns && !split && !spur &&
		!query_group1 && paddr == EPD_OFF_EOI |=> deact_valid)
		else $error("group 0 not deactivated");
	spur_ignore_a: assert property (eoi && spur && !act_valid |=>
		!deact_valid && running_prio == $past(running_prio))
		else $error("spurious id acted on");
	deact_word_a: assert property (deact_valid |-> $past(eoi) &&
		{deact_src, deact_id} == 13'($past(pwdata))) else $error("deact id");
endmodule
bind epd_eoi_ctrl epd_chk u_chk (
	.pclk         (pclk),
	.presetn      (presetn),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pwdata       (pwdata),
	.pprot        (pprot),
	.prdata       (prdata),
	.pready       (pready),
	.act_valid    (act_valid),
	.query_group1 (query_group1),
	.deact_valid  (deact_valid),
	.deact_id     (deact_id),
	.deact_src    (deact_src),
	.running_prio (running_prio)
);

// ==== epd_dist_model.sv ====
// Far-side model: gives the group of an identifier, counts deactivations.
// Assumes identifiers from 512 upward are Group 1, the rest Group 0.
`timescale 1ns/10ps
module epd_dist_model (
	// Clock and reset.
	input wire logic       pclk,
	input wire logic       presetn,
	// Group lookup and deactivation.
	input wire logic [9:0] query_id,
	output logic           query_group1,
	input wire logic       deact_valid,
	output int             deact_cnt
);
	assign query_group1 = query_id[9];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deact_cnt <= 0;
		end else if (deact_valid) begin
			deact_cnt <= deact_cnt + 1;
		end
	end
endmodule

// ==== epd_tb.sv ====
// Directed bench for the end-of-interrupt block over APB.
// Assumes the group model; ce drops only in the freeze scenario.
`timescale 1ns/10ps
module testbench;
	import epd_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0]  pprot = 3'h0;
	logic        act_valid = 1'b0;
	logic [7:0]  act_prio = 8'h00;
	logic        act_group1 = 1'b0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, query_group1, deact_valid, slv;
	logic [9:0]  query_id, deact_id;
	logic [2:0]  deact_src;
	logic [7:0]  running_prio;
	int          deact_cnt;
	int          num_errors = 0;
	int          tests_run = 0;
	epd_eoi_ctrl dut (
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pprot        (pprot),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.act_valid    (act_valid),
		.act_prio     (act_prio),
		.act_group1   (act_group1),
		.query_id     (query_id),
		.query_group1 (query_group1),
		.deact_valid  (deact_valid),
		.deact_id     (deact_id),
		.deact_src    (deact_src),
		.running_prio (running_prio)
	);
	epd_dist_model model (
		.pclk         (pclk),
		.presetn      (presetn),
		.query_id     (query_id),
		.query_group1 (query_group1),
		.deact_valid  (deact_valid),
		.deact_cnt    (deact_cnt)
	);
	initial forever #4 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Holds the request until pready is seen, however long that takes.
	task automatic io(input logic w, input logic [11:0] a,
		input logic [15:0] d, input logic n);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		pprot <= {1'b0, n, 1'b0};
		@(posedge pclk);
		penable <= 1'b1;
		// Ends on pready; only the watchdog ends a wait that never sees it.
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic n, input logic [7:0] e);
		io(1'b0, EPD_OFF_RPR, 16'h0000, n);
		chk(rdat, {24'h0, e});
	endtask
	task automatic act(input logic [7:0] p, input logic g);
		@(posedge pclk);
		act_valid <= 1'b1;
		act_prio <= p;
		act_group1 <= g;
		@(posedge pclk);
		act_valid <= 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(1'b0, 8'hFF);
		io(1'b0, 12'h020, 16'h0000, 1'b0);
		chk({31'h0, slv}, 32'h0000_0001);
		act(8'h20, 1'b0);
		act(8'h40, 1'b1);
		rd(1'b0, 8'h20);
		rd(1'b1, 8'h00);
		io(1'b1, EPD_OFF_EOI, 16'h0040, 1'b1);
		rd(1'b0, 8'h20);
		io(1'b1, EPD_OFF_EOI, 16'h1440, 1'b0);
		rd(1'b0, 8'h40);
		chk(32'(deact_cnt), 32'h0000_0001);
		chk({19'h0, deact_src, deact_id}, 32'h0000_1440);
		io(1'b1, EPD_OFF_EOI, 16'h0241, 1'b1);
		rd(1'b0, 8'hFF);
		chk(32'(deact_cnt), 32'h0000_0002);
		io(1'b1, EPD_OFF_CTRL, 16'h0002, 1'b0);
		act(8'h10, 1'b0);
		act(8'h50, 1'b1);
		io(1'b1, EPD_OFF_EOI, 16'h0042, 1'b0);
		rd(1'b0, 8'h50);
		chk(32'(deact_cnt), 32'h0000_0002);
		io(1'b1, EPD_OFF_EOI, 16'h0242, 1'b1);
		rd(1'b0, 8'hFF);
		chk(32'(deact_cnt), 32'h0000_0003);
		io(1'b1, EPD_OFF_CTRL, 16'h0001, 1'b0);
		act(8'h60, 1'b0);
		act(8'h08, 1'b1);
		rd(1'b1, 8'h00);
		io(1'b1, EPD_OFF_EOI, 16'h0243, 1'b0);
		rd(1'b0, 8'h60);
		io(1'b1, EPD_OFF_EOI, 16'h03FC, 1'b0);
		rd(1'b0, 8'h60);
		chk({24'h0, running_prio}, 32'h0000_0060);
		chk(32'(deact_cnt), 32'h0000_0004);
		io(1'b1, EPD_OFF_EOI, 16'h0044, 1'b0);
		act(8'hA0, 1'b1);
		rd(1'b1, 8'h40);
		rd(1'b0, 8'hA0);
		io(1'b1, EPD_OFF_CTRL, 16'h0000, 1'b0);
		io(1'b1, EPD_OFF_AEOI, 16'h0245, 1'b0);
		rd(1'b0, 8'hFF);
		chk(32'(deact_cnt), 32'h0000_0006);
		// A frozen block must not record an activation.
		@(posedge pclk);
		ce <= 1'b0;
		act(8'h30, 1'b0);
		@(posedge pclk);
		ce <= 1'b1;
		rd(1'b0, 8'hFF);
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
